//--- src/bsc_map.vh
// Constants for the bus controller access path.
// Assumes inclusion by bare name from the design files.
`ifndef BSC_MAP_VH
`define BSC_MAP_VH
// Address partitions (addr[31:28])
`define BSC_PART_CACHE    4'h0
`define BSC_PART_ONCHIP   4'h1
// Peripheral windows (addr[31:8])
`define BSC_PER_WIN_A     24'hfffffc
`define BSC_PER_WIN_B     24'hfffffe
`define BSC_PER_WIN_C     24'hffffff
// Peripheral latencies in clocks
`define BSC_PER_CYC_A     3'h3
`define BSC_PER_CYC_B     3'h4
`define BSC_PER_CYC_C     3'h2
// Index of the last cache line fill beat (four beats per line)
`define BSC_FILL_BEATS    2'h3
// Refresh interval
`define BSC_RFSH_INTERVAL 8'hff
// Access sizes
`define BSC_SIZE_BYTE     2'h0
`define BSC_SIZE_WORD     2'h1
`define BSC_SIZE_LONG     2'h2
// Cache index width
`define BSC_IDX_W         4
`endif

//--- src/bsc_line_mem.v
// Cache data words, registered read.
// Assumes one clock; ports by word index.
`timescale 1ns/10ps
`default_nettype none
module bsc_line_mem (
  // Clock
  input  wire        sys_clk_i,
  // Write port
  input  wire        we_i,
  input  wire [5:0]  waddr_i,
  input  wire [31:0] wdata_i,
  // Read port
  input  wire [5:0]  raddr_i,
  output reg  [31:0] rdata_o
);
  reg [31:0] mem [0:63]; // Storage array

  ////////////////////////////////////////////////////////////////////
  // Write and registered read; a read in the same cycle returns the old word
  always @(posedge sys_clk_i) begin
    if (we_i) begin
      mem[waddr_i] <= wdata_i;
    end
    rdata_o <= mem[raddr_i];
  end
endmodule // bsc_line_mem
`default_nettype wire

//--- src/bsc_access_path.v
// Bus controller access path and write buffer.
// Handles manual and power-on reset.
// Assumes one-cycle CPU/DMA requests on sys_clk_i.
// External bus answers with ext_done_i.
`timescale 1ns/10ps
`default_nettype none
`include "bsc_map.vh"

module bsc_access_path (
  // Clock and resets
  input  wire        sys_clk_i,
  input  wire        nrst_i,
  input  wire        manual_rst_i,
  input  wire        sleep_i,
  // Configuration load (kept across manual reset)
  input  wire        cfg_we_i,
  input  wire        cfg_cache_en_i,
  input  wire        cfg_sdram_i,
  // CPU request on the cache bus
  input  wire        cpu_req_i,
  input  wire        cpu_we_i,
  input  wire        cpu_fetch_i,
  input  wire [1:0]  cpu_size_i,
  input  wire [31:0] cpu_addr_i,
  input  wire [31:0] cpu_wdata_i,
  output wire        cpu_ack_o,
  output reg  [31:0] cpu_rdata_o,
  // DMA request on the internal bus
  input  wire        dma_req_i,
  input  wire        dma_we_i,
  input  wire        dma_dual_i,
  input  wire        dma_src_ext_i,
  input  wire        dma_dst_ext_i,
  input  wire        dma_single_sdram_i,
  input  wire [31:0] dma_addr_i,
  input  wire [31:0] dma_wdata_i,
  output wire        dma_ack_o,
  output reg  [31:0] dma_rdata_o,
  output reg         dma_acknowledge_o,
  // External bus
  output reg         ext_req_o,
  output reg         ext_we_o,
  output reg  [31:0] ext_addr_o,
  output reg  [1:0]  ext_size_o,
  output reg  [31:0] ext_wdata_o,
  output reg         ext_oe_o,
  output reg         area_chip_select_o,
  output reg         byte_lane_mask_o,
  input  wire        ext_done_i,
  input  wire [31:0] ext_rdata_i,
  // Peripheral bus
  output reg         per_req_o,
  output reg         per_we_o,
  output reg  [31:0] per_addr_o,
  output reg  [31:0] per_wdata_o,
  input  wire [31:0] per_rdata_i,
  // Arbitration and refresh
  input  wire        bus_release_request_i,
  output reg         bus_grant_o,
  output reg         refresh_req_o
);
  // Main states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_SRCH = 3'h1; // Cache search cycle
  localparam [2:0] ST_DEC  = 3'h2; // Extra decode cycle
  localparam [2:0] ST_EXT  = 3'h3; // External single access
  localparam [2:0] ST_FILL = 3'h4; // Line fill beats
  localparam [2:0] ST_PER  = 3'h5; // Peripheral access
  localparam [2:0] ST_RCV  = 3'h6; // Write recovery / precharge

  reg [2:0]  st_q;                 // Current state
  reg        own_dma_q;            // Current access belongs to DMA
  reg        cur_we_q;             // Current access is a write
  reg [31:0] cur_addr_q;           // Current access address
  reg [31:0] cur_wdata_q;          // Current write data
  reg [1:0]  beat_q;               // Fill beat counter
  reg [2:0]  per_cnt_q;            // Peripheral latency counter
  reg        cfg_cache_en_q;       // Cache enable configuration
  reg        cfg_sdram_q;          // Sdram configured for normal space
  reg        wb_full_q;            // Write buffer occupied
  reg [31:0] wb_addr_q;            // Buffered write address
  reg [31:0] wb_data_q;            // Buffered write data
  reg        wb_busy_q;            // Buffered write on external bus
  reg        wb_sdram_q;           // Last write went to sdram
  reg [7:0]  refresh_interval_counter_q; // Refresh timer
  reg [`BSC_IDX_W-1:0] tag_v_q;    // Unused marker width guard
  reg [19:0] tag_q [0:15];         // Line tags
  reg [15:0] valid_q;              // Line valid bits
  reg        brq_s1_q;             // Release request sync stage 1
  reg        brq_s2_q;             // Release request sync stage 2
  reg        mrst_s1_q;            // Manual reset sync stage 1
  reg        mrst_s2_q;            // Manual reset sync stage 2
  reg        cpu_ack_q;            // CPU completion pulse
  reg        dma_ack_q;            // DMA completion pulse
  reg        mem_we;               // Line memory write strobe
  reg  [5:0] mem_waddr;            // Line memory write index
  wire [31:0] mem_rdata;           // Line memory read data
  integer    i;                    // Loop index

  // Address decode helpers
  function is_cache;
    input [31:0] a;
    begin
      is_cache = (a[31:28] == `BSC_PART_CACHE);
    end
  endfunction

  function is_per;
    input [31:0] a;
    begin
      is_per = (a[31:8] == `BSC_PER_WIN_A) || (a[31:8] == `BSC_PER_WIN_B) ||
               (a[31:8] == `BSC_PER_WIN_C);
    end
  endfunction

  function [2:0] per_lat;
    input [31:0] a;
    begin
      if (a[31:8] == `BSC_PER_WIN_A) begin
        per_lat = `BSC_PER_CYC_A;
      end else if (a[31:8] == `BSC_PER_WIN_B) begin
        per_lat = `BSC_PER_CYC_B;
      end else begin
        per_lat = `BSC_PER_CYC_C;
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Line memory instance
  bsc_line_mem u_mem (
    .sys_clk_i (sys_clk_i),
    .we_i      (mem_we),
    .waddr_i   (mem_waddr),
    .wdata_i   (ext_done_i ? ext_rdata_i : cur_wdata_q),
    .raddr_i   (cpu_addr_i[7:2]),
    .rdata_o   (mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always @(posedge sys_clk_i) begin
    brq_s1_q  <= bus_release_request_i;
    brq_s2_q  <= brq_s1_q;
    mrst_s1_q <= manual_rst_i;
    mrst_s2_q <= mrst_s1_q;
  end

  wire hit = valid_q[cur_addr_q[7:4]] &&
             (tag_q[cur_addr_q[7:4]] == cur_addr_q[27:8]);
  wire ext_idle = !wb_busy_q && (st_q != ST_EXT) && (st_q != ST_FILL);

  // Line write strobe: fills and hits
  always @* begin
    mem_we    = 1'b0;
    mem_waddr = {cur_addr_q[7:4], beat_q};
    if (st_q == ST_FILL && ext_done_i && !mrst_s2_q) begin
      mem_we = 1'b1;
    end else if (st_q == ST_SRCH && cur_we_q && hit) begin
      mem_we    = 1'b1;
      mem_waddr = cur_addr_q[7:2];
    end
  end

  assign cpu_ack_o = cpu_ack_q;
  assign dma_ack_o = dma_ack_q;

  ////////////////////////////////////////////////////////////////////
  // Configuration: cleared by power-on only
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cfg_cache_en_q <= 1'b0;
      cfg_sdram_q    <= 1'b0;
    end else if (cfg_we_i) begin
      cfg_cache_en_q <= cfg_cache_en_i;
      cfg_sdram_q    <= cfg_sdram_i;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Refresh interval counter
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      refresh_interval_counter_q <= 8'h00;
      refresh_req_o              <= 1'b0;
    end else if (mrst_s2_q || sleep_i) begin
      refresh_req_o <= 1'b0;
    end else if (refresh_interval_counter_q == `BSC_RFSH_INTERVAL) begin
      refresh_interval_counter_q <= 8'h00;
      refresh_req_o              <= 1'b1;
    end else begin
      refresh_interval_counter_q <= refresh_interval_counter_q + 8'h01;
      refresh_req_o              <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus release, not newly granted in manual reset
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      bus_grant_o <= 1'b0;
    end else if (!brq_s2_q) begin
      bus_grant_o <= 1'b0;
    end else if (!mrst_s2_q && st_q == ST_IDLE && !wb_busy_q) begin
      bus_grant_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Main sequencer
  always @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      st_q               <= ST_IDLE;
      own_dma_q          <= 1'b0;
      cur_we_q           <= 1'b0;
      cur_addr_q         <= 32'h0000_0000;
      cur_wdata_q        <= 32'h0000_0000;
      beat_q             <= 2'h0;
      per_cnt_q          <= 3'h0;
      wb_full_q          <= 1'b0;
      wb_addr_q          <= 32'h0000_0000;
      wb_data_q          <= 32'h0000_0000;
      wb_busy_q          <= 1'b0;
      wb_sdram_q         <= 1'b0;
      valid_q            <= 16'h0000;
      tag_v_q            <= {`BSC_IDX_W{1'b0}};
      cpu_ack_q          <= 1'b0;
      dma_ack_q          <= 1'b0;
      cpu_rdata_o        <= 32'h0000_0000;
      dma_rdata_o        <= 32'h0000_0000;
      dma_acknowledge_o  <= 1'b0;
      ext_req_o          <= 1'b0;
      ext_oe_o           <= 1'b0;
      ext_we_o           <= 1'b0;
      ext_addr_o         <= 32'h0000_0000;
      ext_size_o         <= `BSC_SIZE_LONG;
      ext_wdata_o        <= 32'h0000_0000;
      area_chip_select_o <= 1'b0;
      byte_lane_mask_o   <= 1'b0;
      per_req_o          <= 1'b0;
      per_we_o           <= 1'b0;
      per_addr_o         <= 32'h0000_0000;
      per_wdata_o        <= 32'h0000_0000;
      for (i = 0; i < 16; i = i + 1) begin
        tag_q[i] <= 20'h00000;
      end
    end else begin
      cpu_ack_q <= 1'b0;
      dma_ack_q <= 1'b0;
      per_req_o <= 1'b0;
      // Buffered write drains in parallel
      if (wb_busy_q && ext_done_i && st_q != ST_FILL && st_q != ST_EXT) begin
        wb_busy_q        <= 1'b0;
        wb_full_q        <= 1'b0;
        ext_req_o        <= 1'b0;
        ext_oe_o         <= 1'b0;
        byte_lane_mask_o <= 1'b0;
        area_chip_select_o <= 1'b0;
      end else if (wb_full_q && !wb_busy_q && (st_q == ST_IDLE ||
                   st_q == ST_PER) && !bus_grant_o) begin
        wb_busy_q          <= 1'b1;
        ext_req_o          <= 1'b1;
        ext_we_o           <= 1'b1;
        ext_oe_o           <= 1'b1;
        ext_addr_o         <= wb_addr_q;
        ext_wdata_o        <= wb_data_q;
        ext_size_o         <= `BSC_SIZE_LONG;
        area_chip_select_o <= 1'b1;
        byte_lane_mask_o   <= wb_sdram_q;
      end
      case (st_q)
        ST_IDLE: begin
          dma_acknowledge_o <= 1'b0;
          if (mrst_s2_q || bus_grant_o) begin
            st_q <= ST_IDLE;
          end else if (dma_req_i && !(dma_dual_i && !dma_we_i &&
                       dma_src_ext_i && dma_dst_ext_i && wb_full_q)) begin
            // DMA never enters the cache
            own_dma_q   <= 1'b1;
            cur_we_q    <= dma_we_i;
            cur_addr_q  <= dma_addr_i;
            cur_wdata_q <= dma_wdata_i;
            st_q        <= ST_DEC;
          end else if (cpu_req_i) begin
            own_dma_q   <= 1'b0;
            cur_we_q    <= cpu_we_i;
            cur_addr_q  <= cpu_addr_i;
            cur_wdata_q <= cpu_wdata_i;
            if (is_cache(cpu_addr_i) && cfg_cache_en_q) begin
              st_q <= ST_SRCH;
            end else begin
              st_q <= ST_DEC;
            end
          end
        end
        ST_SRCH: begin
          if (cur_we_q) begin
            st_q <= ST_DEC;
          end else if (hit) begin
            cpu_rdata_o <= mem_rdata;
            cpu_ack_q   <= 1'b1;
            st_q        <= ST_IDLE;
          end else if (!ext_idle || wb_full_q) begin
            st_q <= ST_SRCH;
          end else begin
            beat_q     <= 2'h0;
            ext_req_o  <= 1'b1;
            ext_we_o   <= 1'b0;
            ext_oe_o   <= 1'b0;
            ext_size_o <= `BSC_SIZE_LONG;
            ext_addr_o <= {cur_addr_q[31:4], 4'h0};
            area_chip_select_o <= 1'b1;
            st_q       <= ST_FILL;
          end
        end
        ST_DEC: begin
          // Downward paths only: cache->internal->peripheral
          if (is_per(cur_addr_q)) begin
            per_cnt_q   <= per_lat(cur_addr_q);
            per_we_o    <= cur_we_q;
            per_addr_o  <= cur_addr_q;
            per_wdata_o <= cur_wdata_q;
            st_q        <= ST_PER;
          end else if (cur_we_q) begin
            if (wb_full_q) begin
              st_q <= ST_DEC;
            end else begin
              wb_full_q  <= 1'b1;
              wb_addr_q  <= cur_addr_q;
              wb_data_q  <= cur_wdata_q;
              wb_sdram_q <= cfg_sdram_q && !own_dma_q;
              cpu_ack_q  <= !own_dma_q;
              dma_ack_q  <= own_dma_q;
              dma_acknowledge_o <= own_dma_q && dma_single_sdram_i;
              st_q       <= (own_dma_q && dma_single_sdram_i) ? ST_RCV : ST_IDLE;
            end
          end else if (!ext_idle || wb_full_q) begin
            st_q <= ST_DEC;
          end else begin
            ext_req_o  <= 1'b1;
            ext_we_o   <= 1'b0;
            ext_oe_o   <= 1'b0;
            ext_addr_o <= cur_addr_q;
            ext_size_o <= (cpu_fetch_i && !own_dma_q) ? `BSC_SIZE_LONG : cpu_size_i;
            // Select meets mask negation
            area_chip_select_o <= 1'b1;
            byte_lane_mask_o   <= 1'b0;
            dma_acknowledge_o  <= own_dma_q;
            st_q       <= ST_EXT;
          end
        end
        ST_EXT: begin
          if (ext_done_i) begin
            ext_req_o          <= 1'b0;
            area_chip_select_o <= 1'b0;
            if (own_dma_q) begin
              dma_rdata_o <= ext_rdata_i;
              dma_ack_q   <= 1'b1;
            end else begin
              cpu_rdata_o <= ext_rdata_i;
              cpu_ack_q   <= 1'b1;
            end
            st_q <= (own_dma_q && dma_single_sdram_i) ? ST_RCV : ST_IDLE;
          end
        end
        ST_FILL: begin
          if (ext_done_i) begin
            if (beat_q == cur_addr_q[3:2]) begin
              cpu_rdata_o <= ext_rdata_i;
              cpu_ack_q   <= 1'b1;
            end
            if (mrst_s2_q) begin
              ext_req_o          <= 1'b0;
              area_chip_select_o <= 1'b0;
              valid_q[cur_addr_q[7:4]] <= 1'b0;
              st_q <= ST_IDLE;
            end else if (beat_q == `BSC_FILL_BEATS) begin
              ext_req_o          <= 1'b0;
              area_chip_select_o <= 1'b0;
              valid_q[cur_addr_q[7:4]] <= 1'b1;
              tag_q[cur_addr_q[7:4]]   <= cur_addr_q[27:8];
              st_q <= ST_IDLE;
            end else begin
              beat_q     <= beat_q + 2'h1;
              ext_addr_o <= {cur_addr_q[31:4], beat_q + 2'h1, 2'h0};
            end
          end
        end
        ST_PER: begin
          per_req_o <= (per_cnt_q == 3'h1);
          if (per_cnt_q == 3'h1) begin
            if (own_dma_q) begin
              dma_rdata_o <= per_rdata_i;
              dma_ack_q   <= 1'b1;
            end else begin
              cpu_rdata_o <= per_rdata_i;
              cpu_ack_q   <= 1'b1;
            end
            st_q <= ST_IDLE;
          end else begin
            per_cnt_q <= per_cnt_q - 3'h1;
          end
        end
        ST_RCV: begin
          // Acknowledge held in recovery
          dma_acknowledge_o <= 1'b1;
          st_q              <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // bsc_access_path
`default_nettype wire

//--- verif/bsc_ext_model.sv
// External memory and peripheral stand-in for the access path.
// Assumes requests and qualifiers stand until done.
`timescale 1ns/10ps
`default_nettype none
module bsc_ext_model (
  // Clock and pacing
  input  wire logic        sys_clk_i,
  input  wire logic [4:0]  wait_i,
  // External bus
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  output var  logic        done_o,
  output var  logic [31:0] rdata_o,
  // Peripheral bus
  input  wire logic [31:0] per_addr_i,
  output wire logic [31:0] per_rdata_o
);
  logic [4:0] cnt_q = 5'h0;  // Cycles spent on the current beat
  ////////////////////////////////////////////////////////////////
  // Answer each beat after wait_i cycles, slow or prompt
  always @(posedge sys_clk_i) begin
    done_o <= 1'h0;
    if (req_i && !done_o) begin
      cnt_q <= cnt_q + 5'h1;
      if (cnt_q >= wait_i) begin  // Done once the count reaches wait_i, reads and writes alike
        done_o <= 1'h1;
        cnt_q <= 5'h0;
        rdata_o <= {addr_i[15:0], ~addr_i[15:0]};
      end
    end else begin
      // Released bus shows a changing pattern
      cnt_q <= 5'h0;
      rdata_o <= ~rdata_o;
    end
  end
  // Register data derived from the address
  assign per_rdata_o = {per_addr_i[15:0], 16'h5a5a};
endmodule  // bsc_ext_model
`default_nettype wire

//--- verif/bsc_checker.sv
// Assertion checker for the access path top-level ports.
// Assumes one clock and a synchronous active-low power-on reset.
`timescale 1ns/10ps
`default_nettype none
module bsc_checker (
  // Clock and resets
  input wire logic        sys_clk_i,
  input wire logic        nrst_i,
  input wire logic        manual_rst_i,
  // Observed signals
  input wire logic        cpu_ack_o,
  input wire logic        dma_ack_o,
  input wire logic        ext_req_o,
  input wire logic        ext_oe_o,
  input wire logic        area_chip_select_o,
  input wire logic [31:0] ext_addr_o,
  input wire logic        ext_done_i,
  input wire logic        bus_release_request_i,
  input wire logic        bus_grant_o,
  input wire logic        refresh_req_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////
  // Power-on reset drops the bus by the next clock
  property p_por_quiet;
    disable iff (1'h0) !nrst_i |=> !ext_req_o && !ext_oe_o && !area_chip_select_o;
  endproperty
  property p_cpu_ack;
    cpu_ack_o |=> !cpu_ack_o;
  endproperty
  property p_dma_ack;
    dma_ack_o |=> !dma_ack_o;
  endproperty
  property p_ext_hold;
    ext_req_o && !ext_done_i |=> ext_req_o && $stable(ext_addr_o);
  endproperty
  property p_cs_req;
    ext_req_o |-> area_chip_select_o;
  endproperty
  property p_mrst_rfsh;
    manual_rst_i [*4] |-> !refresh_req_o;
  endproperty
  property p_mrst_idle;
    manual_rst_i [*8] ##0 !ext_req_o |=> !ext_req_o;
  endproperty
  property p_mrst_grant;
    manual_rst_i [*6] ##0 !bus_grant_o |=> !bus_grant_o;
  endproperty
  property p_keep_grant;
    bus_release_request_i [*3] ##0 (manual_rst_i && bus_grant_o) |=> bus_grant_o;
  endproperty
  property p_rfsh_pulse;
    refresh_req_o |=> !refresh_req_o [*8];
  endproperty
  a_por_quiet: assert property (p_por_quiet) else $error("bus active in reset");
  a_cpu_ack: assert property (p_cpu_ack) else $error("cpu ack too long");
  a_dma_ack: assert property (p_dma_ack) else $error("dma ack too long");
  a_ext_hold: assert property (p_ext_hold) else $error("ext cycle dropped");
  a_cs_req: assert property (p_cs_req) else $error("no chip select");
  a_mrst_rfsh: assert property (p_mrst_rfsh) else $error("refresh in reset");
  a_mrst_idle: assert property (p_mrst_idle) else $error("new cycle in reset");
  a_mrst_grant: assert property (p_mrst_grant) else $error("grant in reset");
  a_keep_grant: assert property (p_keep_grant) else $error("grant lost");
  a_rfsh_pulse: assert property (p_rfsh_pulse) else $error("refresh too close");
  // Main scenarios reached
  c_ack: cover property (cpu_ack_o);
  c_beat: cover property (ext_req_o && ext_done_i);
  c_grant_mrst: cover property (bus_grant_o && manual_rst_i);
endmodule  // bsc_checker
`default_nettype wire

//--- verif/test_bus_controller_reset_and_access_path.sv
// Self-checking bench for the bus controller access path.
// Assumes design, model and checker compiled with it.
`timescale 1ns/10ps
`default_nettype none
module test_bus_controller_reset_and_access_path;
  typedef struct packed {logic we; logic [31:0] addr, lat, data;} bsc_row_t;
  // Stimulus
  logic        sys_clk_i, nrst_i = 1'h0, manual_rst_i = 1'h0, sleep_i = 1'h0;
  logic        cfg_we_i = 1'h0, cfg_cache_en_i = 1'h0, cfg_sdram_i = 1'h0;
  logic        cpu_req_i = 1'h0, cpu_we_i = 1'h0, cpu_fetch_i = 1'h0;
  logic        dma_req_i = 1'h0, dma_we_i = 1'h0, dma_dual_i = 1'h0, dma_src_ext_i = 1'h0;
  logic        dma_dst_ext_i = 1'h0, dma_single_sdram_i = 1'h0, bus_release_request_i = 1'h0;
  logic [1:0]  cpu_size_i = 2'h0;
  logic [31:0] cpu_addr_i = 32'h0, cpu_wdata_i = 32'h0, dma_addr_i = 32'h0, dma_wdata_i = 32'h0;
  logic [4:0]  wait_q = 5'h2;
  // Design outputs and model answers
  logic        cpu_ack_o, dma_ack_o, dma_acknowledge_o, ext_req_o, ext_we_o, ext_oe_o;
  logic        area_chip_select_o, byte_lane_mask_o, ext_done_i, per_req_o, per_we_o;
  logic        bus_grant_o, refresh_req_o, req_d = 1'h0;
  logic [1:0]  ext_size_o, first_size;
  logic [31:0] cpu_rdata_o, dma_rdata_o, ext_addr_o, ext_wdata_o, ext_rdata_i, rd, first_addr;
  logic [31:0] per_addr_o, per_wdata_o, per_rdata_i;
  int          errors = 0, tests_run = 0, n, beats = 0, bad_size = 0, rf = 0, cyc = 0;
  // Rows: write, address, latency (0 skips), read data
  bsc_row_t    rows [5] = '{'{1'h0, 32'hfffffc10, 32'h5, 32'hfc105a5a},
                            '{1'h0, 32'hfffffe20, 32'h6, 32'hfe205a5a},
                            '{1'h0, 32'hffffff30, 32'h4, 32'hff305a5a},
                            '{1'h1, 32'h20000040, 32'h2, 32'h0},
                            '{1'h0, 32'h20000040, 32'h0, 32'h0040ffbf}};
  bsc_access_path u_dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .manual_rst_i(manual_rst_i),
    .sleep_i(sleep_i), .cfg_we_i(cfg_we_i), .cfg_cache_en_i(cfg_cache_en_i),
    .cfg_sdram_i(cfg_sdram_i), .cpu_req_i(cpu_req_i), .cpu_we_i(cpu_we_i),
    .cpu_fetch_i(cpu_fetch_i), .cpu_size_i(cpu_size_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_ack_o(cpu_ack_o), .cpu_rdata_o(cpu_rdata_o),
    .dma_req_i(dma_req_i), .dma_we_i(dma_we_i), .dma_dual_i(dma_dual_i),
    .dma_src_ext_i(dma_src_ext_i), .dma_dst_ext_i(dma_dst_ext_i),
    .dma_single_sdram_i(dma_single_sdram_i), .dma_addr_i(dma_addr_i), .dma_wdata_i(dma_wdata_i),
    .dma_ack_o(dma_ack_o), .dma_rdata_o(dma_rdata_o), .dma_acknowledge_o(dma_acknowledge_o),
    .ext_req_o(ext_req_o), .ext_we_o(ext_we_o), .ext_addr_o(ext_addr_o),
    .ext_size_o(ext_size_o), .ext_wdata_o(ext_wdata_o), .ext_oe_o(ext_oe_o),
    .area_chip_select_o(area_chip_select_o), .byte_lane_mask_o(byte_lane_mask_o),
    .ext_done_i(ext_done_i), .ext_rdata_i(ext_rdata_i), .per_req_o(per_req_o),
    .per_we_o(per_we_o), .per_addr_o(per_addr_o), .per_wdata_o(per_wdata_o),
    .per_rdata_i(per_rdata_i), .bus_release_request_i(bus_release_request_i),
    .bus_grant_o(bus_grant_o), .refresh_req_o(refresh_req_o));
  bsc_ext_model u_mem (.sys_clk_i(sys_clk_i), .wait_i(wait_q), .req_i(ext_req_o),
    .addr_i(ext_addr_o), .done_o(ext_done_i), .rdata_o(ext_rdata_i),
    .per_addr_i(per_addr_o), .per_rdata_o(per_rdata_i));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // CPU access: one-cycle request, qualifiers held
  task automatic cpu_op(input logic we, input logic fe, input logic [1:0] sz,
                        input logic [31:0] a, output logic [31:0] r, output int k);
    k = 0;
    @(posedge sys_clk_i);
    {cpu_req_i, cpu_we_i, cpu_fetch_i, cpu_size_i, cpu_addr_i, cpu_wdata_i} <= {1'h1, we, fe, sz, a, ~a};
    @(posedge sys_clk_i);
    cpu_req_i <= 1'h0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (cpu_ack_o !== 1'h1 && k < 300);
    r = cpu_rdata_o;
  endtask
  // DMA read, no bank-active or mid-DMA config read
  task automatic dma_rd(input logic [31:0] a, output logic [31:0] r);
    int k = 0;
    @(posedge sys_clk_i);
    {dma_req_i, dma_single_sdram_i, dma_addr_i} <= {1'h1, 1'h1, a};
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (dma_ack_o !== 1'h1 && k < 300);
    r = dma_rdata_o;
    dma_req_i <= 1'h0;
  endtask
  task automatic wrap_up;
    $display("checks %0d, errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Clock, watchdog and bus monitors
  initial begin
    sys_clk_i = 1'h0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    cyc++;
    if (ext_req_o && ext_done_i) beats++;
    if (ext_req_o && ext_done_i && ext_size_o !== 2'h2) bad_size++;
    if (ext_req_o && !req_d) {first_addr, first_size} = {ext_addr_o, ext_size_o};
    req_d = ext_req_o;
    if (refresh_req_o) rf++;
    if (cyc == 20000) begin
      errors++;
      $display("unexpected at %0t: run timed out", $time);
      wrap_up();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk_i);
    nrst_i <= 1'h1;
    repeat (2) @(posedge sys_clk_i);
    chk({ext_req_o, ext_oe_o, area_chip_select_o, bus_grant_o, ext_size_o}, 32'h2);
    foreach (rows[i]) begin
      cpu_op(rows[i].we, 1'h0, 2'h2, rows[i].addr, rd, n);
      if (rows[i].lat != 0) chk(n, rows[i].lat);
      if (!rows[i].we) chk(rd, rows[i].data);
    end
    cpu_op(1'h0, 1'h1, 2'h0, 32'h20000200, rd, n);
    chk(first_size, 2'h2);
    cpu_op(1'h0, 1'h0, 2'h0, 32'h20000203, rd, n);
    chk({first_addr, first_size}, {32'h20000203, 2'h0});
    cfg_cache_en_i <= 1'h1;
    cfg_we_i <= 1'h1;
    @(posedge sys_clk_i);
    {cfg_we_i, beats, bad_size} <= {1'h0, 64'h0};
    cpu_op(1'h0, 1'h0, 2'h1, 32'h00000086, rd, n);
    repeat (20) @(posedge sys_clk_i);
    chk(beats, 4);
    chk(bad_size, 0);
    cpu_op(1'h0, 1'h0, 2'h2, 32'h00000084, rd, n);
    chk({n[7:0], rd}, {8'h2, 32'h0084ff7b});
    dma_rd(32'h00000088, rd);
    chk(first_addr, 32'h88);
    chk(rd, 32'h0088ff77);
    chk(dma_acknowledge_o, 1'h1);
    wait_q <= 5'h14;
    cpu_op(1'h1, 1'h0, 2'h2, 32'h20000100, rd, n);
    cpu_op(1'h0, 1'h0, 2'h2, 32'hfffffc00, rd, n);
    chk({n[7:0], ext_req_o}, {8'h5, 1'h1});
    cpu_op(1'h1, 1'h0, 2'h2, 32'h20000104, rd, n);
    chk(n > 2, 1'h1);
    {manual_rst_i, beats, rf} <= {1'h1, 64'h0};
    repeat (300) @(posedge sys_clk_i);
    chk({beats[3:0], ext_req_o, rf[3:0]}, {4'h1, 1'h0, 4'h0});
    bus_release_request_i <= 1'h1;
    repeat (20) @(posedge sys_clk_i);
    chk(bus_grant_o, 1'h0);
    manual_rst_i <= 1'h0;
    repeat (20) @(posedge sys_clk_i);
    chk(bus_grant_o, 1'h1);
    manual_rst_i <= 1'h1;
    repeat (20) @(posedge sys_clk_i);
    chk(bus_grant_o, 1'h1);
    {bus_release_request_i, manual_rst_i, sleep_i} <= 3'h1;
    repeat (20) @(posedge sys_clk_i);
    {sleep_i, rf} <= {1'h0, 32'h0};
    repeat (300) @(posedge sys_clk_i);
    chk({rf > 0, bus_grant_o}, 2'h2);
    cpu_op(1'h0, 1'h0, 2'h2, 32'h00000084, rd, n);
    chk(n, 2);
    cpu_op(1'h1, 1'h0, 2'h2, 32'h20000300, rd, n);
    repeat (3) @(posedge sys_clk_i);
    nrst_i <= 1'h0;
    repeat (3) @(posedge sys_clk_i);
    chk({ext_req_o, ext_oe_o, area_chip_select_o}, 32'h0);
    nrst_i <= 1'h1;
    cpu_op(1'h0, 1'h0, 2'h2, 32'h00000084, rd, n);
    chk(first_addr, 32'h84);
    wrap_up();
  end
endmodule  // test_bus_controller_reset_and_access_path
bind bsc_access_path bsc_checker u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
  .manual_rst_i(manual_rst_i), .cpu_ack_o(cpu_ack_o), .dma_ack_o(dma_ack_o),
  .ext_req_o(ext_req_o), .ext_oe_o(ext_oe_o), .area_chip_select_o(area_chip_select_o),
  .ext_addr_o(ext_addr_o), .ext_done_i(ext_done_i), .bus_grant_o(bus_grant_o),
  .bus_release_request_i(bus_release_request_i), .refresh_req_o(refresh_req_o));
`default_nettype wire
